/* hdl/cmpe_map.svh */
// Register offsets, field positions, reset values and timing counts for the comparator event block
`ifndef CMPE_MAP_SVH
`define CMPE_MAP_SVH
`define CMPE_ADDR_W 4
`define CMPE_OFF_CFG0 4'h0
`define CMPE_OFF_CFG1 4'h1
`define CMPE_OFF_AUXPWR 4'h2
`define CMPE_OFF_STATUS 4'h3
`define CMPE_CFG_EN 0
`define CMPE_CFG_POS_SEL 1
`define CMPE_CFG_NEG_SEL 2
`define CMPE_CFG_PIN_OUT 3
`define CMPE_CFG_IRQ_EN 4
`define CMPE_CFG_FLAG 5
`define CMPE_CFG_RESULT 6
`define CMPE_AUX_CMP_OFF 5
`define CMPE_CFG_RESET 8'h00
`define CMPE_AUX_RESET 8'h00
`define CMPE_SETTLE_US 10
`define CMPE_CLK_MHZ 40
`define CMPE_SETTLE_CYC (`CMPE_SETTLE_US * `CMPE_CLK_MHZ)
`endif

/* hdl/cmpe_pkg.sv */
// Types shared by the comparator event block
package cmpe_pkg;
    typedef struct packed {
        logic irq_en;
        logic pin_out;
        logic neg_sel;
        logic pos_sel;
        logic en;
    } cmpe_cfg_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cmpe_bus_t;

    typedef enum logic [2:0] {
        CMPE_RUN = 3'h1,
        CMPE_SLEEP = 3'h2,
        CMPE_TOTAL_OFF = 3'h4
    } cmpe_pwr_t;
endpackage : cmpe_pkg

/* hdl/cmpe_sync.sv */
// Two-stage synchroniser for the raw comparator outputs
`timescale 1ns/100ps
module cmpe_sync (
    input wire logic clk,
    input wire logic reset,
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic s1;
        logic s2;
    } cmpe_sync_st_t;
    cmpe_sync_st_t st_q, st_d;

    always_comb begin
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
    end

    // Resets high, matching a disabled comparator
    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= 2'h3;
        end else begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.s2;
endmodule : cmpe_sync

/* hdl/cmpe_chan.sv */
// One comparator channel: forced output, change flag and interrupt request
`timescale 1ns/100ps
module cmpe_chan (
    input wire logic clk,
    input wire logic reset,
    input wire logic analog_sync,
    input wire logic active,
    input wire logic irq_en,
    input wire logic flag_clear,
    output logic comparator_result_bit,
    output logic comparator_change_flag,
    output logic irq
);
    typedef struct packed {
        logic res;
        logic flag;
    } cmpe_chan_st_t;
    cmpe_chan_st_t st_q, st_d;
    logic res_next;
    logic change;

    always_comb begin
        res_next = active ? analog_sync : 1'b1;
        change = res_next != st_q.res;
        st_d.res = res_next;
        // Set beats a clear in the same cycle
        st_d.flag = change | (st_q.flag & ~flag_clear);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= 2'h2;
        end else begin
            st_q <= st_d;
        end
    end

    assign comparator_result_bit = st_q.res;
    assign comparator_change_flag = st_q.flag;
    assign irq = st_q.flag & irq_en;

    flag_on_change_a: assert property (@(posedge clk) disable iff (reset)
        $changed(st_q.res) |-> st_q.flag)
        else $error("change flag missed an output change");
    forced_high_a: assert property (@(posedge clk) disable iff (reset)
        !active |=> st_q.res)
        else $error("disabled comparator output not high");
    flag_hold_a: assert property (@(posedge clk) disable iff (reset)
        st_q.flag && !flag_clear |=> st_q.flag)
        else $error("change flag dropped without a clear");
endmodule : cmpe_chan

/* hdl/cmpe_top.sv */
// Comparator control and event logic: selection, result bits, flags, shared interrupt, power modes
// How it works
// - Result bit is one when selected positive input exceeds selected negative input.
// - Per comparator, positive input picks one of two pins, negative pin or reference.
// - A change flag sets whenever a comparator result bit changes.
// - With its interrupt enabled, a result change raises an interrupt request.
// - Both comparators share one interrupt output; software reads both flags.
// - A disabled comparator forces its result bit high.
// - Disabling with result low sets the flag and may interrupt.
// - Comparators run in idle and power-down, forced off in total power-down.
// - In idle or power-down an enabled change interrupts and wakes the processor.
// - Bit 5 of the auxiliary power control register disables both comparators.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`include "cmpe_map.svh"
module cmpe_top (
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic [1:0] analog_out,
    input wire logic idle_mode,
    input wire logic powerdown_mode,
    input wire logic total_powerdown,
    output logic [1:0] core_enable,
    output logic [1:0] pos_select,
    output logic [1:0] neg_select_ref,
    output logic [1:0] result_pin,
    output logic [1:0] result_pin_en,
    output logic irq,
    output logic wake,
    output logic [1:0] settling
);
    typedef struct packed {
        cmpe_pkg::cmpe_cfg_t [1:0] cfg;
        logic cmp_off;
        logic [7:0] rdata;
        logic [1:0] core_en;
        logic [1:0] pin;
        logic irq;
        logic wake;
        logic [1:0][8:0] settle_cnt;
        cmpe_pkg::cmpe_pwr_t pwr;
    } cmpe_st_t;

    localparam logic [8:0] SETTLE_CYC = 9'(`CMPE_SETTLE_CYC);

    cmpe_st_t st_q, st_d;
    logic [1:0] sync_out;
    logic [1:0] active;
    logic [1:0] res_bit;
    logic [1:0] flag_bit;
    logic [1:0] chan_irq;
    logic [1:0] flag_clr;
    logic [7:0] cfg_rd [2];

    // Power mode tracker; total power-down overrides the lighter sleep modes
    always_comb begin
        st_d = st_q;
        if (total_powerdown) begin
            st_d.pwr = cmpe_pkg::CMPE_TOTAL_OFF;
        end else if (idle_mode || powerdown_mode) begin
            st_d.pwr = cmpe_pkg::CMPE_SLEEP;
        end else begin
            st_d.pwr = cmpe_pkg::CMPE_RUN;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_chan
            cmpe_sync u_sync (
                .clk(clk),
                .reset(reset),
                .din(analog_out[gi]),
                .dout(sync_out[gi])
            );
            // Total power-down acts at once, not a cycle later
            assign active[gi] = st_q.cfg[gi].en & ~st_q.cmp_off & ~total_powerdown;
            assign flag_clr[gi] = wr && (addr == (gi == 0 ? `CMPE_OFF_CFG0 : `CMPE_OFF_CFG1))
                && !wdata[`CMPE_CFG_FLAG];
            cmpe_chan u_chan (
                .clk(clk),
                .reset(reset),
                .analog_sync(sync_out[gi]),
                .active(active[gi]),
                .irq_en(st_q.cfg[gi].irq_en),
                .flag_clear(flag_clr[gi]),
                .comparator_result_bit(res_bit[gi]),
                .comparator_change_flag(flag_bit[gi]),
                .irq(chan_irq[gi])
            );
            assign cfg_rd[gi] = {1'b0, res_bit[gi], flag_bit[gi], st_q.cfg[gi].irq_en,
                st_q.cfg[gi].pin_out, st_q.cfg[gi].neg_sel, st_q.cfg[gi].pos_sel, st_q.cfg[gi].en};
        end
    endgenerate

    // Register writes, read mux and outputs
    cmpe_st_t st_w;
    always_comb begin
        st_w = st_d;
        if (wr) begin
            if (addr == `CMPE_OFF_CFG0) begin
                st_w.cfg[0] = wdata[4:0];
            end else if (addr == `CMPE_OFF_CFG1) begin
                st_w.cfg[1] = wdata[4:0];
            end else if (addr == `CMPE_OFF_AUXPWR) begin
                st_w.cmp_off = wdata[`CMPE_AUX_CMP_OFF];
            end
        end
        if (rd) begin
            if (addr == `CMPE_OFF_CFG0) begin
                st_w.rdata = cfg_rd[0];
            end else if (addr == `CMPE_OFF_CFG1) begin
                st_w.rdata = cfg_rd[1];
            end else if (addr == `CMPE_OFF_AUXPWR) begin
                st_w.rdata = {2'h0, st_q.cmp_off, 5'h00};
            end else if (addr == `CMPE_OFF_STATUS) begin
                st_w.rdata = {3'h0, active, st_q.pwr};
            end else begin
                st_w.rdata = 8'h00;
            end
        end else begin
            st_w.rdata = 8'h00;
        end
        st_w.core_en = active;
        st_w.pin = res_bit;
        st_w.irq = |chan_irq;
        // Wake only from sleep; total power-down holds cores off
        st_w.wake = (|chan_irq) && (st_q.pwr == cmpe_pkg::CMPE_SLEEP);
        for (int i = 0; i < 2; i++) begin
            if (!active[i]) begin
                st_w.settle_cnt[i] = 9'h000;
            end else if (!st_q.core_en[i]) begin
                st_w.settle_cnt[i] = SETTLE_CYC;
            end else if (st_q.settle_cnt[i] != 9'h000) begin
                st_w.settle_cnt[i] = st_q.settle_cnt[i] - 9'h001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_q.cfg <= 10'h000;
            st_q.cmp_off <= 1'b0;
            st_q.rdata <= 8'h00;
            st_q.core_en <= 2'h0;
            st_q.pin <= 2'h3;
            st_q.irq <= 1'b0;
            st_q.wake <= 1'b0;
            st_q.settle_cnt <= 18'h00000;
            st_q.pwr <= cmpe_pkg::CMPE_RUN;
        end else begin
            st_q <= st_w;
        end
    end

    // Drive pins low-active enable only where routing is on
    logic [1:0] pin_oe_q;
    logic [1:0] pos_q;
    logic [1:0] neg_q;
    logic [1:0] settling_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_oe_q <= 2'h3;
            pos_q <= 2'h0;
            neg_q <= 2'h0;
            settling_q <= 2'h0;
        end else begin
            pin_oe_q <= ~{st_w.cfg[1].pin_out, st_w.cfg[0].pin_out};
            pos_q <= {st_w.cfg[1].pos_sel, st_w.cfg[0].pos_sel};
            neg_q <= {st_w.cfg[1].neg_sel, st_w.cfg[0].neg_sel};
            settling_q <= {st_w.settle_cnt[1] != 9'h000, st_w.settle_cnt[0] != 9'h000};
        end
    end

    assign rdata = st_q.rdata;
    assign core_enable = st_q.core_en;
    assign pos_select = pos_q;
    assign neg_select_ref = neg_q;
    assign result_pin = st_q.pin;
    assign result_pin_en = pin_oe_q;
    assign irq = st_q.irq;
    assign wake = st_q.wake;
    assign settling = settling_q;

    shared_irq_a: assert property (@(posedge clk) disable iff (reset)
        (chan_irq != 2'h0) |=> irq)
        else $error("shared interrupt not raised");
    aux_off_a: assert property (@(posedge clk) disable iff (reset)
        st_q.cmp_off |-> active == 2'h0)
        else $error("comparators active with power bit set");
    total_off_a: assert property (@(posedge clk) disable iff (reset)
        total_powerdown |=> core_enable == 2'h0 ##1 result_pin == 2'h3)
        else $error("comparators running in total power-down");
    sleep_wake_a: assert property (@(posedge clk) disable iff (reset)
        (chan_irq != 2'h0) && st_q.pwr == cmpe_pkg::CMPE_SLEEP |=> wake)
        else $error("no wake on comparator event in sleep");
    disable_flag_a: assert property (@(posedge clk) disable iff (reset)
        active[0] && $past(active[0]) ##1 !active[0] && !res_bit[0] |=> flag_bit[0])
        else $error("disabling from low did not set flag");
endmodule : cmpe_top

/* test/cmpe_analog_model.sv */
// Behavioural model of the two analog comparator cores
`timescale 1ns/100ps
module cmpe_analog_model #(parameter int REF_MV = 1230) (
    input wire logic clk,
    input wire logic [1:0] core_enable,
    input wire logic [1:0] pos_select,
    input wire logic [1:0] neg_select_ref,
    input wire logic [1:0][11:0] pos_a_mv,
    input wire logic [1:0][11:0] pos_b_mv,
    input wire logic [1:0][11:0] neg_mv,
    output logic [1:0] analog_out
);
    logic junk_q = 1'b0;
    // A powered-off core gives no valid level: toggle so leakage shows
    always @(posedge clk) junk_q <= ~junk_q;
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (!core_enable[i])
                analog_out[i] = junk_q;
            else
                analog_out[i] = (pos_select[i] ? pos_b_mv[i] : pos_a_mv[i]) >
                    (neg_select_ref[i] ? 12'(REF_MV) : neg_mv[i]);
        end
    end
endmodule : cmpe_analog_model

/* test/tb_cmpe_top.sv */
// Self-checking bench for the comparator event block
`timescale 1ns/100ps
`include "cmpe_map.svh"
module tb_cmpe_top;
    logic clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic [1:0] analog_out, core_enable, pos_select, neg_select_ref, result_pin, result_pin_en, settling;
    logic idle_mode = 1'b0, powerdown_mode = 1'b0, total_powerdown = 1'b0, irq, wake;
    logic [1:0][11:0] pos_a_mv = {12'h1F4, 12'h3E8}, pos_b_mv = {12'h1F4, 12'h7D0}, neg_mv = {12'h384, 12'h5DC};
    int errors = 0, n_tests = 0, cyc = 0;
    always #12.5 clk = ~clk;
    cmpe_top dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .analog_out(analog_out), .idle_mode(idle_mode), .powerdown_mode(powerdown_mode),
        .total_powerdown(total_powerdown), .core_enable(core_enable), .pos_select(pos_select),
        .neg_select_ref(neg_select_ref), .result_pin(result_pin), .result_pin_en(result_pin_en),
        .irq(irq), .wake(wake), .settling(settling));
    cmpe_analog_model model (.clk(clk), .core_enable(core_enable), .pos_select(pos_select),
        .neg_select_ref(neg_select_ref), .pos_a_mv(pos_a_mv), .pos_b_mv(pos_b_mv), .neg_mv(neg_mv),
        .analog_out(analog_out));
    task test_done;
        if (errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd_chk
    // Sync takes two edges, result and flag one more together, irq one after that
    task settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            test_done;
        end
    end
    initial begin
        logic [1:0] k;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        rd_chk(`CMPE_OFF_CFG0, 8'h40);
        rd_chk(4'h7, 8'h00);
        for (int i = 0; i < 4; i++) begin
            k = 2'(i);
            wr_reg(`CMPE_OFF_CFG0, 8'h09 | {5'h00, k, 1'b0});
            settle(6);
            rd_chk(`CMPE_OFF_CFG0, 8'h29 | {1'b0, k[0], 3'h0, k, 1'b0});
            chk({4'h0, pos_select[0], neg_select_ref[0], result_pin[0], result_pin_en[0]},
                {4'h0, k[0], k[1], k[0], 1'b0});
            chk({6'h00, settling}, 8'h01);
        end
        // Honour the settle time before arming the interrupt
        settle(400);
        chk({6'h00, settling}, 8'h00);
        wr_reg(`CMPE_OFF_CFG0, 8'h1F);
        settle(2);
        chk({7'h00, irq}, 8'h00);
        pos_b_mv[0] <= 12'h3E8;
        settle(6);
        chk({7'h00, irq}, 8'h01);
        rd_chk(`CMPE_OFF_CFG0, 8'h3F);
        rd_chk(`CMPE_OFF_CFG1, 8'h40);
        wr_reg(`CMPE_OFF_CFG0, 8'h3F);
        rd_chk(`CMPE_OFF_CFG0, 8'h3F);
        wr_reg(`CMPE_OFF_CFG0, 8'h1F);
        rd_chk(`CMPE_OFF_CFG0, 8'h1F);
        chk({7'h00, irq}, 8'h00);
        idle_mode <= 1'b1;
        pos_b_mv[0] <= 12'h7D0;
        settle(6);
        chk({6'h00, irq, wake}, 8'h03);
        rd_chk(`CMPE_OFF_STATUS, 8'h0A);
        idle_mode <= 1'b0;
        pos_b_mv[0] <= 12'h3E8;
        settle(6);
        wr_reg(`CMPE_OFF_CFG0, 8'h1F);
        wr_reg(`CMPE_OFF_CFG0, 8'h1E);
        settle(6);
        rd_chk(`CMPE_OFF_CFG0, 8'h7E);
        chk({7'h00, irq}, 8'h01);
        wr_reg(`CMPE_OFF_CFG0, 8'h0E);
        settle(2);
        chk({7'h00, irq}, 8'h00);
        wr_reg(`CMPE_OFF_CFG0, 8'h07);
        wr_reg(`CMPE_OFF_CFG1, 8'h01);
        settle(6);
        wr_reg(`CMPE_OFF_CFG1, 8'h01);
        chk({6'h00, core_enable}, 8'h03);
        wr_reg(`CMPE_OFF_AUXPWR, 8'h20);
        settle(6);
        chk({6'h00, core_enable}, 8'h00);
        rd_chk(`CMPE_OFF_CFG1, 8'h61);
        rd_chk(`CMPE_OFF_AUXPWR, 8'h20);
        wr_reg(`CMPE_OFF_AUXPWR, 8'h00);
        settle(6);
        powerdown_mode <= 1'b1;
        total_powerdown <= 1'b1;
        settle(6);
        chk({6'h00, core_enable}, 8'h00);
        rd_chk(`CMPE_OFF_STATUS, 8'h04);
        rd_chk(`CMPE_OFF_CFG0, 8'h67);
        chk({7'h00, wake}, 8'h00);
        test_done;
    end
endmodule : tb_cmpe_top
